/* File: shared/sdbsc_pkg.sv */
// Purpose: Shared types and constants for the bank command state block.
// Assumes: One clock at 100 MHz; two banks; sequential burst order.
// Notes: Burst length and timings are fixed defaults, not mode-register driven.
package sdbsc_pkg;

  // Geometry
  localparam int NUM_BANKS = 2;
  localparam int COL_W = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BURST_LEN = 4'h4;
  localparam logic [COL_W-1:0] BURST_MASK = 8'h03;

  // Timing, in ns and derived cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RP_NS = 20;
  localparam int T_DPL_NS = 10;
  localparam logic [CNT_W-1:0] RP_CYC =
    CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DPL_CYC =
    CNT_W'((T_DPL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Decoded command kinds
  typedef enum logic [3:0] {
    SDBSC_DESL, SDBSC_NOP, SDBSC_BST, SDBSC_RD, SDBSC_WR,
    SDBSC_ACT, SDBSC_PRE, SDBSC_REF, SDBSC_MRS
  } sdbsc_cmd_kind_t;

  // Bank states
  typedef enum logic [3:0] {
    SDBSC_IDLE, SDBSC_ROW_ACT, SDBSC_READ, SDBSC_WRITE,
    SDBSC_READ_AP, SDBSC_WRITE_AP, SDBSC_WREC, SDBSC_WREC_AP,
    SDBSC_PRECHG
  } sdbsc_state_t;

  // Command pins as sampled on the rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank;
    logic a10;
    logic [COL_W-1:0] col;
  } sdbsc_cmd_t;

  // Per-bank status
  typedef struct packed {
    sdbsc_state_t state;
    logic [COL_W-1:0] col;
    logic rd_beat;
    logic wr_beat;
  } sdbsc_bank_stat_t;

  // Map pin levels to a command kind
  function automatic sdbsc_cmd_kind_t sdbsc_decode(input sdbsc_cmd_t c);
    sdbsc_cmd_kind_t k;
    k = SDBSC_DESL;
    if (!c.cs_n)
    begin
      unique case ({c.ras_n, c.cas_n, c.we_n})
        3'b111: k = SDBSC_NOP;
        3'b110: k = SDBSC_BST;
        3'b101: k = SDBSC_RD;
        3'b100: k = SDBSC_WR;
        3'b011: k = SDBSC_ACT;
        3'b010: k = SDBSC_PRE;
        3'b001: k = SDBSC_REF;
        3'b000: k = SDBSC_MRS;
      endcase
    end
    return k;
  endfunction

  // Next column inside the burst, wrapping on the burst boundary
  function automatic logic [COL_W-1:0] sdbsc_next_col(input logic [COL_W-1:0] c);
    logic [COL_W-1:0] inc;
    inc = c + 8'h01;
    return (c & ~BURST_MASK) | (inc & BURST_MASK);
  endfunction

endpackage

/* File: hdl/sdbsc_timer.sv */
// Purpose: Down-counter that times a recovery or precharge period.
// Assumes: Load value is at least one cycle.
// Notes: done is high in the last cycle of the period.
module sdbsc_timer
  import sdbsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // Status
  output logic done
);

  logic [CNT_W-1:0] cnt_reg;

  // Count down to zero, reload on request
  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= load_val;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 4'h1;
  end

  // Last cycle of the period; from the count only, so a reload fed by done makes no loop
  assign done = (cnt_reg == 4'h1);

endmodule

/* File: hdl/sdbsc_top.sv */
// Purpose: Per-bank command state machine for a two-bank synchronous DRAM.
// Assumes: Controller obeys command legality; pins share the clock domain.
// Notes: Covers burst, auto-precharge, recovery and precharge states.
//
// Contract
// - Read burst runs out, then row active
// - Burst stop ends read, row active
// - New read restarts burst at column
// - Write interrupts read, write burst starts
// - Precharge interrupts read, then precharges row
// - Write burst runs out, then recovery
// - Burst stop ends write, row active
// - Read interrupts write, read burst starts
// - New write restarts write at column
// - Precharge interrupts write, then precharges row
// - Read auto-precharge finishes, then precharges
// - Write auto-precharge: recovery then precharge
// - Precharge ignores idle commands, then idle
module sdbsc_top
  import sdbsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Command pins
  input wire sdbsc_cmd_t cmd,
  // Bank status
  output sdbsc_bank_stat_t [NUM_BANKS-1:0] bank_stat
);

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  sdbsc_cmd_kind_t kind;

  // Kind of the command on the pins this cycle
  always_comb
  begin
    kind = sdbsc_decode(cmd);
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst helpers

  // Read burst state, with or without auto-precharge
  function automatic sdbsc_state_t rd_state(input logic ap);
    return ap ? SDBSC_READ_AP : SDBSC_READ;
  endfunction

  // Write burst state, with or without auto-precharge
  function automatic sdbsc_state_t wr_state(input logic ap);
    return ap ? SDBSC_WRITE_AP : SDBSC_WRITE;
  endfunction

  // True in a state that moves read data
  function automatic logic rd_burst(input sdbsc_state_t s);
    return (s == SDBSC_READ) || (s == SDBSC_READ_AP);
  endfunction

  // True in a state that moves write data
  function automatic logic wr_burst(input sdbsc_state_t s);
    return (s == SDBSC_WRITE) || (s == SDBSC_WRITE_AP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bank machines

  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    sdbsc_state_t state_reg;
    sdbsc_state_t state_next;
    logic [COL_W-1:0] col_reg;
    logic [COL_W-1:0] col_next;
    logic [CNT_W-1:0] beat_reg;
    logic [CNT_W-1:0] beat_next;
    logic rd_beat_reg;
    logic wr_beat_reg;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_done;
    logic hit;
    logic pre_hit;
    logic last_beat;

    // Addressing of this bank
    always_comb
    begin
      hit = (cmd.bank == 1'(b));
      pre_hit = (kind == SDBSC_PRE) && (hit || cmd.a10);
      last_beat = (beat_reg == '0);
    end

    // Recovery and precharge period timer
    sdbsc_timer u_timer (
      .clk(clk),
      .srst(srst),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
    );

    // Next state, column and beat count
    always_comb
    begin
      state_next = state_reg;
      col_next = col_reg;
      beat_next = beat_reg;
      tmr_load = 1'b0;
      tmr_val = RP_CYC;
      unique case (state_reg)
        SDBSC_IDLE:
        begin
          if (kind == SDBSC_ACT && hit)
            state_next = SDBSC_ROW_ACT;
        end
        SDBSC_ROW_ACT, SDBSC_WREC:
        begin
          if (state_reg == SDBSC_WREC && tmr_done)
            state_next = SDBSC_ROW_ACT;
          if (kind == SDBSC_RD && hit)
          begin
            state_next = rd_state(cmd.a10);
            col_next = cmd.col;
            beat_next = BURST_LEN - 4'h1;
          end
          else if (kind == SDBSC_WR && hit)
          begin
            state_next = wr_state(cmd.a10);
            col_next = cmd.col;
            beat_next = BURST_LEN - 4'h1;
          end
          else if (state_reg == SDBSC_ROW_ACT && pre_hit)
          begin
            state_next = SDBSC_PRECHG;
            tmr_load = 1'b1;
          end
        end
        SDBSC_READ:
        begin
          if (kind == SDBSC_RD && hit)
          begin
            // Abort and restart at the new column
            state_next = rd_state(cmd.a10);
            col_next = cmd.col;
            beat_next = BURST_LEN - 4'h1;
          end
          else if (kind == SDBSC_WR && hit)
          begin
            // Read cut, write burst follows
            state_next = wr_state(cmd.a10);
            col_next = cmd.col;
            beat_next = BURST_LEN - 4'h1;
          end
          else if (pre_hit)
          begin
            state_next = SDBSC_PRECHG;
            tmr_load = 1'b1;
          end
          // Burst stop cuts the read short
          else if (kind == SDBSC_BST)
            state_next = SDBSC_ROW_ACT;
          else if (last_beat)
            state_next = SDBSC_ROW_ACT;
          else
          begin
            col_next = sdbsc_next_col(col_reg);
            beat_next = beat_reg - 4'h1;
          end
        end
        SDBSC_WRITE:
        begin
          if (kind == SDBSC_RD && hit)
          begin
            // Write cut, read burst follows
            state_next = rd_state(cmd.a10);
            col_next = cmd.col;
            beat_next = BURST_LEN - 4'h1;
          end
          else if (kind == SDBSC_WR && hit)
          begin
            // Restart writing at the new column
            state_next = wr_state(cmd.a10);
            col_next = cmd.col;
            beat_next = BURST_LEN - 4'h1;
          end
          else if (pre_hit)
          begin
            state_next = SDBSC_PRECHG;
            tmr_load = 1'b1;
          end
          // Burst stop ends the write early
          else if (kind == SDBSC_BST)
            state_next = SDBSC_ROW_ACT;
          else if (last_beat)
          begin
            state_next = SDBSC_WREC;
            tmr_load = 1'b1;
            tmr_val = DPL_CYC;
          end
          else
          begin
            col_next = sdbsc_next_col(col_reg);
            beat_next = beat_reg - 4'h1;
          end
        end
        SDBSC_READ_AP:
        begin
          // Only deselect or no-op expected here
          if (last_beat)
          begin
            state_next = SDBSC_PRECHG;
            tmr_load = 1'b1;
          end
          else
          begin
            col_next = sdbsc_next_col(col_reg);
            beat_next = beat_reg - 4'h1;
          end
        end
        SDBSC_WRITE_AP:
        begin
          // Only deselect or no-op expected here
          if (last_beat)
          begin
            state_next = SDBSC_WREC_AP;
            tmr_load = 1'b1;
            tmr_val = DPL_CYC;
          end
          else
          begin
            col_next = sdbsc_next_col(col_reg);
            beat_next = beat_reg - 4'h1;
          end
        end
        SDBSC_WREC_AP:
        begin
          // Recovery done, precharge starts unprompted
          if (tmr_done)
          begin
            state_next = SDBSC_PRECHG;
            tmr_load = 1'b1;
          end
        end
        SDBSC_PRECHG:
        begin
          // Idle, no-op and burst stop change nothing
          if (tmr_done)
            state_next = SDBSC_IDLE;
        end
        default:
        begin
          state_next = SDBSC_IDLE;
        end
      endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
      if (srst)
        state_reg <= SDBSC_IDLE;
      else
        state_reg <= state_next;
    end

    // Column and beat registers
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        col_reg <= '0;
        beat_reg <= '0;
      end
      else
      begin
        col_reg <= col_next;
        beat_reg <= beat_next;
      end
    end

    // Data beat flags, aligned with the state register
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        rd_beat_reg <= 1'b0;
        wr_beat_reg <= 1'b0;
      end
      else
      begin
        rd_beat_reg <= rd_burst(state_next);
        wr_beat_reg <= wr_burst(state_next);
      end
    end

    // Status out, straight from the registers
    assign bank_stat[b].state = state_reg;
    assign bank_stat[b].col = col_reg;
    assign bank_stat[b].rd_beat = rd_beat_reg;
    assign bank_stat[b].wr_beat = wr_beat_reg;
  end

endmodule

/* File: test/sdbsc_ctrl_model.sv */
// Purpose: Controller model that places commands on the bank pins.
// Assumes: Commands change just after the falling edge.
// Notes: Deselect flips the unused pins so no stale command lingers.
module sdbsc_ctrl_model
  import sdbsc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command pins
  output sdbsc_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins start deselected
  initial cmd = {1'b1, 13'h0};

  // Code is {a10, cs_n, ras_n, cas_n, we_n}; only legal sequences are sent
  task automatic issue(input logic [4:0] c, input logic [7:0] col);
    @(negedge clk);
    if (c[3])
      cmd <= {1'b1, ~cmd[12:0]};
    else
      cmd <= {c[3:0], c[4] & (c[3:0] == 4'h2), c[4], col};
  endtask
endmodule

/* File: test/sdbsc_assertions.sv */
// Purpose: Port-level checks of the bank 0 command state behaviour.
// Assumes: Single clock domain, synchronous reset.
// Notes: Commands are decoded by hand from the pins.
module sdbsc_checker
  import sdbsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched signals
  input wire sdbsc_cmd_t cmd,
  input wire sdbsc_bank_stat_t [NUM_BANKS-1:0] bank_stat
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Decoded command flags for bank 0
  sdbsc_state_t s;
  logic [3:0] c;
  logic nop, bst, rd0, wr0, pre0;
  assign s = bank_stat[0].state;
  assign c = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign nop = cmd.cs_n | (c == 4'h7);
  assign bst = c == 4'h6;
  assign rd0 = (c == 4'h5) && !cmd.bank;
  assign wr0 = (c == 4'h4) && !cmd.bank;
  assign pre0 = (c == 4'h2) && (cmd.a10 || !cmd.bank);

  ///////////////////////////////////////////////////////////////////////////
  a_rd_runs_out: assert property (($rose(bank_stat[0].rd_beat) && s == SDBSC_READ
    && nop) ##1 nop [*3] |=> s == SDBSC_ROW_ACT)
    else $error("read burst did not end in row active");
  a_bst_ends_rd: assert property (s == SDBSC_READ && bst |=> s == SDBSC_ROW_ACT)
    else $error("burst stop did not end read");
  a_rd_restart: assert property (s == SDBSC_READ && rd0
    |=> bank_stat[0].rd_beat && bank_stat[0].col == $past(cmd.col)) else $error("no read restart");
  a_wr_in_rd: assert property (s == SDBSC_READ && wr0
    |=> bank_stat[0].wr_beat && bank_stat[0].col == $past(cmd.col)) else $error("no write start");
  a_pre_burst: assert property ((s == SDBSC_READ || s == SDBSC_WRITE) && pre0
    |=> s == SDBSC_PRECHG) else $error("precharge did not cut burst");
  a_wr_runs_out: assert property (($rose(bank_stat[0].wr_beat) && s == SDBSC_WRITE
    && nop) ##1 nop [*3] |=> s == SDBSC_WREC)
    else $error("write burst did not reach recovery");
  a_bst_ends_wr: assert property (s == SDBSC_WRITE && bst |=> s == SDBSC_ROW_ACT)
    else $error("burst stop did not end write");
  a_rd_in_wr: assert property (s == SDBSC_WRITE && rd0
    |=> bank_stat[0].rd_beat && bank_stat[0].col == $past(cmd.col)) else $error("no read start");
  a_wr_restart: assert property (s == SDBSC_WRITE && wr0
    |=> bank_stat[0].wr_beat && bank_stat[0].col == $past(cmd.col)) else $error("no write restart");
  a_rdap_finish: assert property ($rose(bank_stat[0].rd_beat) && s == SDBSC_READ_AP
    |-> ##4 s == SDBSC_PRECHG) else $error("read auto-precharge did not precharge");
  a_wrap_finish: assert property ($rose(bank_stat[0].wr_beat) && s == SDBSC_WRITE_AP
    |-> ##4 s == SDBSC_WREC_AP ##1 s == SDBSC_PRECHG) else $error("write auto-precharge wrong");
  a_prechg_idle: assert property (s == SDBSC_PRECHG && $past(s) != SDBSC_PRECHG
    |=> s == SDBSC_PRECHG ##1 s == SDBSC_IDLE) else $error("precharge period wrong");
endmodule

bind sdbsc_top sdbsc_checker chk_i (.clk(clk), .srst(srst), .cmd(cmd), .bank_stat(bank_stat));

/* File: test/testbench.sv */
// Purpose: Directed scenarios for the bank command state block.
// Assumes: Bank 0 carries the traffic; commands driven at the falling edge.
// Notes: Each step checks state, beat flags and, in burst states only, column one edge later.
module testbench
  import sdbsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  // Command codes {a10, cs_n, ras_n, cas_n, we_n}
  localparam logic [4:0] NOP = 5'h07, DSL = 5'h0f, BST = 5'h06, RD = 5'h05, WR = 5'h04;
  localparam logic [4:0] ACT = 5'h03, PRE = 5'h02, RDA = 5'h15, WRA = 5'h14, PALL = 5'h12;

  logic clk = 1'b0;
  logic srst = 1'b1;
  sdbsc_cmd_t cmd;
  sdbsc_bank_stat_t [NUM_BANKS-1:0] bank_stat;
  int n_errors = 0;
  int tests_run = 0;

  // Clock
  always #5 clk = ~clk;

  // Controller model and block
  sdbsc_ctrl_model m (.clk(clk), .cmd(cmd));
  sdbsc_top dut (.clk(clk), .srst(srst), .cmd(cmd), .bank_stat(bank_stat));

  ///////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One command, then the status of both banks it leads to
  task automatic go(input logic [4:0] c, input logic [7:0] col, input sdbsc_state_t st,
    input logic [7:0] ecol);
    logic rd;
    logic wr;
    rd = st inside {SDBSC_READ, SDBSC_READ_AP};
    wr = st inside {SDBSC_WRITE, SDBSC_WRITE_AP};
    m.issue(c, col);
    @(posedge clk);
    #1;
    chk({bank_stat[0].state, (rd | wr) ? bank_stat[0].col : 8'h00, bank_stat[0].rd_beat,
      bank_stat[0].wr_beat}, {st, ecol, rd, wr});
    chk(bank_stat[1], {SDBSC_IDLE, 8'h00, 2'b00});
  endtask

  // Read burst runs out with wrap
  task automatic t_rd_out();
    go(ACT, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(RD, 8'h05, SDBSC_READ, 8'h05);
    go(NOP, 8'h00, SDBSC_READ, 8'h06);
    go(DSL, 8'h00, SDBSC_READ, 8'h07);
    go(NOP, 8'h00, SDBSC_READ, 8'h04);
    go(NOP, 8'h00, SDBSC_ROW_ACT, 8'h00);
  endtask

  // Back-to-back interruptions of running bursts
  task automatic t_int();
    go(RD, 8'h08, SDBSC_READ, 8'h08);
    go(RD, 8'h0d, SDBSC_READ, 8'h0d);
    go(WR, 8'h20, SDBSC_WRITE, 8'h20);
    go(RD, 8'h31, SDBSC_READ, 8'h31);
    go(BST, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(WR, 8'h40, SDBSC_WRITE, 8'h40);
    go(WR, 8'h42, SDBSC_WRITE, 8'h42);
    go(BST, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(RD, 8'h50, SDBSC_READ, 8'h50);
    go(PRE, 8'h00, SDBSC_PRECHG, 8'h00);
    go(NOP, 8'h00, SDBSC_PRECHG, 8'h00);
    go(BST, 8'h00, SDBSC_IDLE, 8'h00);
  endtask

  // Write burst runs out, then all-bank precharge cuts a write
  task automatic t_wr_out();
    go(ACT, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(WR, 8'h10, SDBSC_WRITE, 8'h10);
    go(NOP, 8'h00, SDBSC_WRITE, 8'h11);
    go(DSL, 8'h00, SDBSC_WRITE, 8'h12);
    go(NOP, 8'h00, SDBSC_WRITE, 8'h13);
    go(NOP, 8'h00, SDBSC_WREC, 8'h00);
    go(NOP, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(WR, 8'h60, SDBSC_WRITE, 8'h60);
    go(PALL, 8'h00, SDBSC_PRECHG, 8'h00);
    go(NOP, 8'h00, SDBSC_PRECHG, 8'h00);
    go(DSL, 8'h00, SDBSC_IDLE, 8'h00);
  endtask

  // Auto-precharge bursts for read and write
  task automatic t_ap();
    go(ACT, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(RDA, 8'h70, SDBSC_READ_AP, 8'h70);
    go(NOP, 8'h00, SDBSC_READ_AP, 8'h71);
    go(NOP, 8'h00, SDBSC_READ_AP, 8'h72);
    go(NOP, 8'h00, SDBSC_READ_AP, 8'h73);
    go(NOP, 8'h00, SDBSC_PRECHG, 8'h00);
    go(NOP, 8'h00, SDBSC_PRECHG, 8'h00);
    go(NOP, 8'h00, SDBSC_IDLE, 8'h00);
    go(ACT, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(WRA, 8'h80, SDBSC_WRITE_AP, 8'h80);
    go(NOP, 8'h00, SDBSC_WRITE_AP, 8'h81);
    go(NOP, 8'h00, SDBSC_WRITE_AP, 8'h82);
    go(NOP, 8'h00, SDBSC_WRITE_AP, 8'h83);
    go(NOP, 8'h00, SDBSC_WREC_AP, 8'h00);
    go(NOP, 8'h00, SDBSC_PRECHG, 8'h00);
    go(NOP, 8'h00, SDBSC_PRECHG, 8'h00);
    go(NOP, 8'h00, SDBSC_IDLE, 8'h00);
  endtask

  // Reset in mid-burst, then a fresh burst after release
  task automatic t_rst();
    go(ACT, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(RD, 8'h24, SDBSC_READ, 8'h24);
    @(negedge clk);
    srst <= 1'b1;
    @(negedge clk);
    srst <= 1'b0;
    chk({bank_stat[0].state, bank_stat[0].col, bank_stat[0].rd_beat, bank_stat[0].wr_beat},
      {SDBSC_IDLE, 8'h00, 2'b00});
    go(ACT, 8'h00, SDBSC_ROW_ACT, 8'h00);
    go(RD, 8'h2e, SDBSC_READ, 8'h2e);
    go(BST, 8'h00, SDBSC_ROW_ACT, 8'h00);
  endtask

  // Counts and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #20000;
    n_errors++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    srst <= 1'b0;
    chk({bank_stat[0].state, bank_stat[0].col, bank_stat[0].rd_beat, bank_stat[0].wr_beat},
      {SDBSC_IDLE, 8'h00, 2'b00});
    t_rd_out();
    t_int();
    t_wr_out();
    t_ap();
    t_rst();
    results();
  end
endmodule
